/* rtl/fifo_pkg.sv */
// shared constants of the programmable-flag fifo and its register slave
package fifo_pkg;

  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  localparam int DATA_W = 9;
  localparam int DEPTH_DEFAULT = 8192;
  localparam int DEPTH_MIN = 64;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] AE_OFFSET_ADDR = 4'h0;
  localparam logic [3:0] AF_OFFSET_ADDR = 4'h4;
  localparam logic [3:0] STATUS_ADDR = 4'h8;

  // threshold reset value, in words from empty or from full
  localparam logic [15:0] OFFSET_RESET = 16'h0007;

  // status word layout
  localparam int ST_EMPTY_N_BIT = 0;
  localparam int ST_AE_N_BIT = 1;
  localparam int ST_AF_N_BIT = 2;
  localparam int ST_FULL_N_BIT = 3;
  localparam int ST_COUNT_LSB = 16;

endpackage

/* rtl/gray_ptr_sync.sv */
// two-stage synchroniser for a gray-coded pointer, advanced by the destination tick
`timescale 1ns/1ns
module gray_ptr_sync #(
  parameter int W = 14
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic clear_in,
  input wire logic tick_in,
  input wire logic [W-1:0] gray_in,
  output logic [W-1:0] gray_out
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;

  // ----------------------------------------------------------------
  // per-bit stages
  // ----------------------------------------------------------------
  // gray pointer crossing
  // only one bit moves per step, so a half-caught change is harmless
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        stage1_r[i] <= 1'b0;
        stage2_r[i] <= 1'b0;
      end else if (clear_in) begin
        stage1_r[i] <= 1'b0;
        stage2_r[i] <= 1'b0;
      end else if (tick_in) begin
        stage1_r[i] <= gray_in[i];
        stage2_r[i] <= stage1_r[i];
      end
    end
  end

  assign gray_out = stage2_r;

endmodule

/* rtl/prog_flag_fifo.sv */
// nine-bit fifo with write and read port strobes, programmable flags, avalon slave
//
// Behaviour
// - write when enable a low, b high
// - one write per write tick, back to back
// - one read per read tick when enabled
// - common or unrelated port rates both work
// - reads and writes proceed independently
// - data in and out nine bits wide
// - depth parameter 64 to 8K words
// - four status flags presented
// - thresholds programmable in single words
// - thresholds reset to seven words
// - empty flags change on read ticks only
// - full flags change on write ticks only
// - flags hold at least one tick
// - writes ignored while full
// - read only when enabled and not empty
// - reset returns buffer to empty
// - output enable high floats data outputs
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
module prog_flag_fifo #(
  parameter int DEPTH = fifo_pkg::DEPTH_DEFAULT
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic buffer_reset_n_in,
  input wire logic write_tick_in,
  input wire logic write_enable_a_in,
  input wire logic write_enable_b_or_load_in,
  input wire logic [fifo_pkg::DATA_W-1:0] write_data_in,
  input wire logic read_tick_in,
  input wire logic read_enable_a_in,
  input wire logic read_enable_b_in,
  input wire logic output_drive_enable_in,
  output logic [fifo_pkg::DATA_W-1:0] read_data_out,
  output logic read_data_oe_n_out,
  output logic empty_flag_n_out,
  output logic almost_empty_flag_n_out,
  output logic almost_full_flag_n_out,
  output logic full_flag_n_out,
  input wire logic [fifo_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_W = DEPTH[AW:0];

  function automatic logic [AW:0] gray_to_bin(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  // nine-bit words
  logic [fifo_pkg::DATA_W-1:0] mem_r [DEPTH];
  logic [AW:0] wr_bin_r;
  logic [AW:0] wr_gray_r;
  logic [AW:0] rd_bin_r;
  logic [AW:0] rd_gray_r;
  logic [AW:0] rd_gray_at_wr;
  logic [AW:0] wr_gray_at_rd;
  logic [AW:0] rd_bin_at_wr;
  logic [AW:0] wr_bin_at_rd;
  logic [AW:0] wr_bin_nxt;
  logic [AW:0] rd_bin_nxt;
  logic [AW:0] wr_count_nxt;
  logic [AW:0] rd_count_nxt;
  logic [AW:0] free_nxt;
  logic [AW:0] rd_count_r;
  logic [AW:0] ae_offset_r;
  logic [AW:0] af_offset_r;
  logic [fifo_pkg::DATA_W-1:0] read_data_r;
  logic oe_n_r;
  logic empty_n_r;
  logic ae_n_r;
  logic af_n_r;
  logic full_n_r;
  logic buf_clear;
  logic wr_accept;
  logic rd_accept;

  assign buf_clear = ~buffer_reset_n_in;
  // either enable may be steered by expansion logic
  assign wr_accept = write_tick_in & ~write_enable_a_in & write_enable_b_or_load_in & full_n_r;
  assign rd_accept = read_tick_in & ~read_enable_a_in & ~read_enable_b_in & empty_n_r;
  assign wr_bin_nxt = wr_accept ? wr_bin_r + 1'b1 : wr_bin_r;
  assign rd_bin_nxt = rd_accept ? rd_bin_r + 1'b1 : rd_bin_r;

  // ----------------------------------------------------------------
  // write side
  // ----------------------------------------------------------------
  // a word every accepted tick
  always_ff @(posedge clk_sys_in) begin
    if (wr_accept) begin
      mem_r[wr_bin_r[AW-1:0]] <= write_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_bin_r <= '0;
      wr_gray_r <= '0;
    end else if (buf_clear) begin
      wr_bin_r <= '0;
      wr_gray_r <= '0;
    end else if (wr_accept) begin
      wr_bin_r <= wr_bin_nxt;
      wr_gray_r <= wr_bin_nxt ^ (wr_bin_nxt >> 1);
    end
  end
  gray_ptr_sync #(
    .W(AW + 1)
  ) u_rd_to_wr (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(buf_clear),
    .tick_in(write_tick_in),
    .gray_in(rd_gray_r),
    .gray_out(rd_gray_at_wr)
  );
  assign rd_bin_at_wr = gray_to_bin(rd_gray_at_wr);
  assign wr_count_nxt = wr_bin_nxt - rd_bin_at_wr;
  assign free_nxt = DEPTH_W - wr_count_nxt;
  // full flags move on write ticks only
  // almost full at or below free-space threshold
  // held until the next write tick at least
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      full_n_r <= 1'b1;
      af_n_r <= 1'b1;
    end else if (buf_clear) begin
      full_n_r <= 1'b1;
      af_n_r <= 1'b1;
    end else if (write_tick_in) begin
      full_n_r <= ~(wr_count_nxt == DEPTH_W);
      af_n_r <= ~(free_nxt <= af_offset_r);
    end
  end

  // ----------------------------------------------------------------
  // read side
  // ----------------------------------------------------------------
  // read pointer owned by read ticks alone
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_bin_r <= '0;
      rd_gray_r <= '0;
    end else if (buf_clear) begin
      rd_bin_r <= '0;
      rd_gray_r <= '0;
    end else if (rd_accept) begin
      rd_bin_r <= rd_bin_nxt;
      rd_gray_r <= rd_bin_nxt ^ (rd_bin_nxt >> 1);
    end
  end

  // one word per accepted read tick
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      read_data_r <= '0;
    end else if (buf_clear) begin
      read_data_r <= '0;
    end else if (rd_accept) begin
      read_data_r <= mem_r[rd_bin_r[AW-1:0]];
    end
  end

  gray_ptr_sync #(
    .W(AW + 1)
  ) u_wr_to_rd (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(buf_clear),
    .tick_in(read_tick_in),
    .gray_in(wr_gray_r),
    .gray_out(wr_gray_at_rd)
  );

  assign wr_bin_at_rd = gray_to_bin(wr_gray_at_rd);
  assign rd_count_nxt = wr_bin_at_rd - rd_bin_nxt;
  // empty flags move on read ticks only
  // almost empty at or below threshold
  // synchronised view is conservative, lagging the write pointer by two read ticks even on a shared tick
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      empty_n_r <= 1'b0;
      ae_n_r <= 1'b0;
      rd_count_r <= '0;
    end else if (buf_clear) begin
      empty_n_r <= 1'b0;
      ae_n_r <= 1'b0;
      rd_count_r <= '0;
    end else if (read_tick_in) begin
      empty_n_r <= ~(rd_count_nxt == '0);
      ae_n_r <= ~(rd_count_nxt <= ae_offset_r);
      rd_count_r <= rd_count_nxt;
    end
  end

  // drive enable is active low at the pin
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= output_drive_enable_in;
    end
  end

  assign empty_flag_n_out = empty_n_r;
  assign almost_empty_flag_n_out = ae_n_r;
  assign almost_full_flag_n_out = af_n_r;
  assign full_flag_n_out = full_n_r;
  assign read_data_out = read_data_r;
  assign read_data_oe_n_out = oe_n_r;

  // ----------------------------------------------------------------
  // avalon slave
  // ----------------------------------------------------------------
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] status_word;
  logic [15:0] wr_lanes;
  logic bus_req;
  logic bus_write_now;
  assign bus_req = avs_read_in | avs_write_in;
  // write lands on the edge where the master sees waitrequest low
  assign bus_write_now = avs_write_in & ~wait_r;
  always_comb begin
    status_word = '0;
    status_word[fifo_pkg::ST_EMPTY_N_BIT] = empty_n_r;
    status_word[fifo_pkg::ST_AE_N_BIT] = ae_n_r;
    status_word[fifo_pkg::ST_AF_N_BIT] = af_n_r;
    status_word[fifo_pkg::ST_FULL_N_BIT] = full_n_r;
    status_word[fifo_pkg::ST_COUNT_LSB +: AW + 1] = rd_count_r;
  end

  // one wait cycle, then a one-cycle answer
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wait_r <= 1'b1;
    end else if (bus_req & wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_r <= '0;
    end else if (avs_read_in & wait_r) begin
      case (avs_address_in)
        fifo_pkg::AE_OFFSET_ADDR: rdata_r <= 32'({ae_offset_r});
        fifo_pkg::AF_OFFSET_ADDR: rdata_r <= 32'({af_offset_r});
        fifo_pkg::STATUS_ADDR: rdata_r <= status_word;
        default: rdata_r <= '0;
      endcase
    end
  end

  always_comb begin
    wr_lanes = 16'(avs_address_in == fifo_pkg::AE_OFFSET_ADDR ? ae_offset_r : af_offset_r);
    if (avs_byteenable_in[0]) begin
      wr_lanes[7:0] = avs_writedata_in[7:0];
    end
    if (avs_byteenable_in[1]) begin
      wr_lanes[15:8] = avs_writedata_in[15:8];
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ae_offset_r <= fifo_pkg::OFFSET_RESET[AW:0];
    end else if (bus_write_now && avs_address_in == fifo_pkg::AE_OFFSET_ADDR) begin
      ae_offset_r <= wr_lanes[AW:0];
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      af_offset_r <= fifo_pkg::OFFSET_RESET[AW:0];
    end else if (bus_write_now && avs_address_in == fifo_pkg::AF_OFFSET_ADDR) begin
      af_offset_r <= wr_lanes[AW:0];
    end
  end

  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = wait_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence two_writes;
    wr_accept & buffer_reset_n_in ##1 wr_accept & buffer_reset_n_in;
  endsequence
  sequence write_while_full;
    write_tick_in & ~write_enable_a_in & write_enable_b_or_load_in & ~full_n_r
      & buffer_reset_n_in;
  endsequence
  chk_write_stores: assert property (
    wr_accept & buffer_reset_n_in |=> wr_bin_r == $past(wr_bin_r) + 1'b1
      && mem_r[$past(wr_bin_r[AW-1:0])] == $past(write_data_in))
    else $error("accepted write not stored");
  chk_back_to_back: assert property (
    two_writes |=> wr_bin_r == $past(wr_bin_r, 2) + 2'd2)
    else $error("consecutive writes lost a word");
  chk_full_ignored: assert property (
    write_while_full |=> wr_bin_r == $past(wr_bin_r))
    else $error("write stored while full");
  chk_read_gate: assert property (
    read_tick_in & buffer_reset_n_in & (~empty_n_r | read_enable_a_in | read_enable_b_in)
      |=> $stable(rd_bin_r))
    else $error("read pointer moved without a valid read");
  chk_read_data: assert property (
    rd_accept & buffer_reset_n_in |=> read_data_out == $past(mem_r[rd_bin_r[AW-1:0]]))
    else $error("read word does not match storage");
  chk_empty_tick: assert property (
    ~read_tick_in & buffer_reset_n_in |=> $stable(empty_flag_n_out)
      && $stable(almost_empty_flag_n_out))
    else $error("empty flags moved off a read tick");
  chk_full_tick: assert property (
    ~write_tick_in & buffer_reset_n_in |=> $stable(full_flag_n_out)
      && $stable(almost_full_flag_n_out))
    else $error("full flags moved off a write tick");
  chk_reset_empty: assert property (
    ~buffer_reset_n_in |=> ~empty_flag_n_out & ~almost_empty_flag_n_out
      & full_flag_n_out & (wr_bin_r == '0) & (rd_bin_r == '0))
    else $error("buffer reset did not empty the fifo");
  chk_output_float: assert property (
    output_drive_enable_in |=> read_data_oe_n_out)
    else $error("data outputs driven while disabled");
  chk_full_count: assert property (
    write_tick_in & buffer_reset_n_in & (wr_count_nxt == DEPTH_W) |=> ~full_flag_n_out)
    else $error("full flag missed a full buffer");

endmodule

/* tb/fifo_port_model.sv */
// producer and consumer model driving the fifo write and read ports
`timescale 1ns/1ns
module fifo_port_model (
  input wire logic clk_sys_in,
  output logic write_tick_out,
  output logic write_enable_a_out,
  output logic write_enable_b_or_load_out,
  output logic [fifo_pkg::DATA_W-1:0] write_data_out,
  output logic read_tick_out,
  output logic read_enable_a_out,
  output logic read_enable_b_out
);
  // ----------------------------------------------------------------
  // free-running port clocks
  // ----------------------------------------------------------------
  // one common rate, or two unrelated rates
  // divisor 1 ticks every cycle; unequal divisors give unrelated ports
  int wr_div = 1;
  int rd_div = 1;
  int wr_cnt = 0;
  int rd_cnt = 0;

  initial begin
    write_enable_a_out = 1'b1;
    write_enable_b_or_load_out = 1'b0;
    write_data_out = 9'h000;
    read_enable_a_out = 1'b1;
    read_enable_b_out = 1'b1;
  end

  always @(posedge clk_sys_in) begin
    wr_cnt <= (wr_cnt + 1 < wr_div) ? wr_cnt + 1 : 0;
    rd_cnt <= (rd_cnt + 1 < rd_div) ? rd_cnt + 1 : 0;
    write_tick_out <= (wr_cnt + 1 >= wr_div);
    read_tick_out <= (rd_cnt + 1 >= rd_div);
  end

  task automatic set_rates(input int w, input int r);
    wr_div <= w;
    rd_div <= r;
    @(posedge clk_sys_in);
  endtask

  // ----------------------------------------------------------------
  // port actions, each returns at the tick edge that sampled it
  // ----------------------------------------------------------------
  // enable a for system control, b for steering
  task automatic push(input logic [8:0] d, input logic ea, input logic eb);
    write_enable_a_out <= ea;
    write_enable_b_or_load_out <= eb;
    write_data_out <= d;
    do begin
      @(posedge clk_sys_in);
    end while (write_tick_out !== 1'b1);
  endtask

  // released data line shows the inverse, not a stale word
  task automatic idle_wr();
    write_enable_a_out <= 1'b1;
    write_enable_b_or_load_out <= 1'b0;
    write_data_out <= ~write_data_out;
    do begin
      @(posedge clk_sys_in);
    end while (write_tick_out !== 1'b1);
  endtask

  task automatic pop(input logic ra, input logic rb);
    read_enable_a_out <= ra;
    read_enable_b_out <= rb;
    do begin
      @(posedge clk_sys_in);
    end while (read_tick_out !== 1'b1);
  endtask

  task automatic halt();
    read_enable_a_out <= 1'b1;
    read_enable_b_out <= 1'b1;
    do begin
      @(posedge clk_sys_in);
    end while (read_tick_out !== 1'b1);
  endtask
endmodule

/* tb/test_prog_flag_fifo.sv */
// self-checking bench of the programmable-flag fifo
`timescale 1ns/1ns
module test_prog_flag_fifo;
  logic clk_sys_in, sys_rst_in, buf_rst_n, oe_ctl, wt, wa, wb, rt, ra, rb;
  logic [8:0] wd, rd;
  logic oe_n, ef_n, ae_n, af_n, ff_n, av_rd, av_wr, wrq;
  logic [3:0] addr, av_be, be_use;
  logic [31:0] av_wd, av_rdata, v;
  int error_cnt, num_checks, cyc;

  prog_flag_fifo #(.DEPTH(64)) dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .buffer_reset_n_in(buf_rst_n), .write_tick_in(wt), .write_enable_a_in(wa),
    .write_enable_b_or_load_in(wb), .write_data_in(wd), .read_tick_in(rt),
    .read_enable_a_in(ra), .read_enable_b_in(rb), .output_drive_enable_in(oe_ctl),
    .read_data_out(rd), .read_data_oe_n_out(oe_n), .empty_flag_n_out(ef_n),
    .almost_empty_flag_n_out(ae_n), .almost_full_flag_n_out(af_n), .full_flag_n_out(ff_n),
    .avs_address_in(addr), .avs_read_in(av_rd), .avs_write_in(av_wr),
    .avs_writedata_in(av_wd), .avs_byteenable_in(av_be), .avs_readdata_out(av_rdata),
    .avs_waitrequest_out(wrq));

  fifo_port_model port (.clk_sys_in(clk_sys_in), .write_tick_out(wt),
    .write_enable_a_out(wa), .write_enable_b_or_load_out(wb), .write_data_out(wd),
    .read_tick_out(rt), .read_enable_a_out(ra), .read_enable_b_out(rb));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until waitrequest is seen low at an edge
  task automatic av_xfer(input logic w, input logic [3:0] a, input logic [31:0] wdat);
    @(posedge clk_sys_in);
    addr <= a;
    av_wr <= w;
    av_rd <= !w;
    av_wd <= wdat;
    av_be <= be_use;
    do begin
      @(posedge clk_sys_in);
    end while (wrq !== 1'b0);
    v = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // hang guard, the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst_in = 1'b1;
    buf_rst_n = 1'b0;
    oe_ctl = 1'b0;
    addr = 4'h0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wd = 32'h0000_0000;
    av_be = 4'h0;
    be_use = 4'hf;
    repeat (6) @(posedge clk_sys_in);
    chk({ef_n, ae_n, af_n, ff_n, oe_n, wrq}, 6'h0f);
    chk(rd, 32'h0000_0000);
    sys_rst_in <= 1'b0;
    buf_rst_n <= 1'b1;
    av_xfer(1'b0, 4'h0, 32'h0000_0000);
    chk(v, 32'h0000_0007);
    av_xfer(1'b0, 4'h4, 32'h0000_0000);
    chk(v, 32'h0000_0007);
    av_xfer(1'b0, 4'h8, 32'h0000_0000);
    chk(v, 32'h0000_000c);
    av_xfer(1'b0, 4'hc, 32'h0000_0000);
    chk(v, 32'h0000_0000);
    $display("test reset done");

    port.push(9'h155, 1'b1, 1'b1);
    port.push(9'h0aa, 1'b0, 1'b0);
    for (int j = 0; j <= 64; j++) begin
      if (j < 64) port.push(9'(j), 1'b0, 1'b1);
      else port.idle_wr();
      if (j > 0) chk({af_n, ff_n}, {j < 57, j < 64});
    end
    port.push(9'h1ff, 1'b0, 1'b1);
    port.idle_wr();
    chk(ff_n, 32'h0000_0000);
    repeat (6) @(posedge clk_sys_in);
    port.pop(1'b1, 1'b0);
    port.pop(1'b0, 1'b1);
    port.halt();
    chk(rd, 32'h0000_0000);
    for (int i = 0; i <= 64; i++) begin
      if (i < 64) port.pop(1'b0, 1'b0);
      else port.halt();
      if (i > 0) chk(rd, i - 1);
      if (i > 0) chk({ef_n, ae_n}, {i < 64, i < 57});
    end
    port.pop(1'b0, 1'b0);
    port.halt();
    chk(rd, 32'h0000_003f);
    $display("test fill drain done");

    av_xfer(1'b1, 4'h0, 32'hffff_0003);
    av_xfer(1'b1, 4'h4, 32'h0000_0002);
    // lane 0 disabled, so the low byte of this write must not land
    be_use = 4'h2;
    av_xfer(1'b1, 4'h0, 32'h0000_0009);
    be_use = 4'hf;
    av_xfer(1'b0, 4'h0, 32'h0000_0000);
    chk(v, 32'h0000_0003);
    av_xfer(1'b0, 4'h4, 32'h0000_0000);
    chk(v, 32'h0000_0002);
    for (int j = 0; j < 4; j++) port.push(9'(j), 1'b0, 1'b1);
    port.idle_wr();
    repeat (6) @(posedge clk_sys_in);
    chk(ae_n, 32'h0000_0001);
    av_xfer(1'b0, 4'h8, 32'h0000_0000);
    chk(v, 32'h0004_000f);
    $display("test thresholds done");

    buf_rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    buf_rst_n <= 1'b1;
    @(posedge clk_sys_in);
    chk({ef_n, ae_n, af_n, ff_n}, 32'h0000_0003);
    av_xfer(1'b0, 4'h0, 32'h0000_0000);
    chk(v, 32'h0000_0003);
    $display("test buffer reset done");

    // unrelated port rates, the reader lags far enough never to starve
    port.set_rates(2, 3);
    fork
      begin
        for (int j = 0; j < 20; j++) port.push(9'h100 + 9'(j), 1'b0, 1'b1);
        port.idle_wr();
      end
      begin
        repeat (20) @(posedge clk_sys_in);
        for (int i = 0; i <= 12; i++) begin
          if (i < 12) port.pop(1'b0, 1'b0);
          else port.halt();
          if (i > 0) chk(rd, 32'h100 + i - 1);
        end
      end
    join
    port.set_rates(1, 1);
    $display("test concurrent done");

    oe_ctl <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk(oe_n, 32'h0000_0001);
    oe_ctl <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    chk(oe_n, 32'h0000_0000);
    $display("test output drive done");
    results();
  end
endmodule
